// >>> hdl/stmr_defines.vh
// register offsets, field positions, reset values and clock select codes
// assumes inclusion by the standard timer top module only
`ifndef STMR_DEFINES_VH
`define STMR_DEFINES_VH

// ==========================================================
// register byte addresses
`define STMR_OFS_CTRL_A   8'h00
`define STMR_OFS_CTRL_B   8'h04
`define STMR_OFS_CNT_LO   8'h08
`define STMR_OFS_CNT_HI   8'h0c
`define STMR_OFS_CMPA_LO  8'h10
`define STMR_OFS_CMPA_HI  8'h14
`define STMR_OFS_CMPP     8'h18
`define STMR_OFS_FLAGS    8'h1c

// ==========================================================
// control a fields
`define STMR_PAUSE_BIT    7
`define STMR_CKSEL_HI     6
`define STMR_CKSEL_LO     4
`define STMR_ON_BIT       3
`define STMR_CTRL_A_MASK  8'hf8

// ==========================================================
// control b fields
`define STMR_MODE_HI      7
`define STMR_MODE_LO      6
`define STMR_PINF_HI      5
`define STMR_PINF_LO      4
`define STMR_OLVL_BIT     3
`define STMR_INV_BIT      2
`define STMR_SWAP_BIT     1
`define STMR_CLR_BIT      0

// ==========================================================
// flag register fields
`define STMR_FLAG_A_BIT   0
`define STMR_FLAG_P_BIT   1

// ==========================================================
// modes and clock selections
`define STMR_MODE_CMP     2'h0
`define STMR_MODE_CAP     2'h1
`define STMR_MODE_PWM     2'h2
`define STMR_MODE_TMR     2'h3
`define STMR_CK_SYS4      3'h0
`define STMR_CK_SYS       3'h1
`define STMR_CK_HI16      3'h2
`define STMR_CK_HI64      3'h3
`define STMR_CK_SUB0      3'h4
`define STMR_CK_SUB1      3'h5
`define STMR_CK_EXTR      3'h6
`define STMR_CK_EXTF      3'h7

// ==========================================================
// reset values and dividers
`define STMR_RST_BYTE     8'h00
`define STMR_RST_CNT      16'h0000
`define STMR_DIV_SYS      4
`define STMR_DIV_HI16     16
`define STMR_DIV_HI64     64

`endif

// >>> hdl/stmr_top.v
// standard timer: 16-bit up counter, comparators a and p, axi4-lite registers
// assumes high_clock and sub_clock tick inputs are one-cycle strobes on aclk,
// external pins are asynchronous and synchronised here
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`include "stmr_defines.vh"

module stmr_top (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // internal clock ticks
   input  wire        high_clock,
   input  wire        sub_clock,
   // pins
   input  wire        ext_clock_pin,
   input  wire        capture_pin,
   output reg         timer_out_pin0,
   output reg         timer_out_pin1,
   output reg         timer_out_en
);

   // ==========================================================
   // registers
   reg  [7:0]  timer_control_a;
   reg  [7:0]  timer_control_b;
   reg  [15:0] compare_a_value;
   reg  [7:0]  compare_p_value;
   reg  [15:0] count;
   reg         compare_a_flag;
   reg         compare_p_flag;
   reg         out_level;
   reg         pulse_on_clr;
   reg         pulse_on_set;
   reg         on_prev;

   wire        pause_ctl        = timer_control_a[`STMR_PAUSE_BIT];
   wire [2:0]  clock_source_sel = timer_control_a[`STMR_CKSEL_HI:`STMR_CKSEL_LO];
   wire        counter_on       = timer_control_a[`STMR_ON_BIT];
   wire [1:0]  op_mode          = {timer_control_b[`STMR_MODE_HI], timer_control_b[`STMR_MODE_LO]};
   wire [1:0]  pin_function     = {timer_control_b[`STMR_PINF_HI], timer_control_b[`STMR_PINF_LO]};
   wire        output_level_ctl = timer_control_b[`STMR_OLVL_BIT];
   wire        output_invert    = timer_control_b[`STMR_INV_BIT];
   wire        period_duty_swap = timer_control_b[`STMR_SWAP_BIT];
   wire        clear_source_sel = timer_control_b[`STMR_CLR_BIT];

   // ==========================================================
   // pin synchronisers
   reg  [1:0]  ext_sync;
   reg  [1:0]  cap_sync;
   reg         ext_last;
   reg         cap_last;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 2'h0;
         cap_sync <= 2'h0;
         ext_last <= 1'b0;
         cap_last <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[0], ext_clock_pin};
         cap_sync <= {cap_sync[0], capture_pin};
         ext_last <= ext_sync[1];
         cap_last <= cap_sync[1];
      end
   end

   wire ext_rise = ext_sync[1] & ~ext_last;
   wire ext_fall = ~ext_sync[1] & ext_last;
   wire cap_rise = cap_sync[1] & ~cap_last;
   wire cap_fall = ~cap_sync[1] & cap_last;

   // ==========================================================
   // clock prescaler
   reg  [1:0]  sys_div;
   reg  [5:0]  hi_div;

   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_div <= 2'h0;
         hi_div  <= 6'h00;
      end else begin
         sys_div <= sys_div + 2'h1;
         if (high_clock)
            hi_div <= hi_div + 6'h01;
      end
   end

   reg tick;
   always @* begin
      case (clock_source_sel)
         `STMR_CK_SYS4: tick = (sys_div == `STMR_DIV_SYS - 1);
         `STMR_CK_SYS:  tick = 1'b1;
         `STMR_CK_HI16: tick = high_clock & (hi_div[3:0] == `STMR_DIV_HI16 - 1);
         `STMR_CK_HI64: tick = high_clock & (hi_div == `STMR_DIV_HI64 - 1);
         `STMR_CK_SUB0: tick = sub_clock;
         `STMR_CK_SUB1: tick = sub_clock;
         `STMR_CK_EXTR: tick = ext_rise;
         `STMR_CK_EXTF: tick = ext_fall;
         default:       tick = 1'b0;
      endcase
   end

   // ==========================================================
   // counter and comparators
   wire on_rise  = counter_on & ~on_prev;
   wire running  = counter_on & ~pause_ctl;
   wire step     = running & tick;
   wire is_pwm   = (op_mode == `STMR_MODE_PWM);
   wire is_cap   = (op_mode == `STMR_MODE_CAP);
   wire single   = is_pwm & (pin_function == 2'h3);
   wire a_match  = step & (count == compare_a_value);
   wire p_zero   = (compare_p_value == 8'h00);
   wire p_match  = step & (p_zero ? (count == 16'hffff)
                                  : (count[15:8] == compare_p_value - 8'h01) && (count[7:0] == 8'hff));
   // clear choice; pwm follows swap except single pulse, which never clears, capture always p
   wire clr_by_a = is_pwm ? (period_duty_swap & ~single) : (is_cap ? 1'b0 : clear_source_sel);
   wire cnt_clr  = single ? 1'b0 : (clr_by_a ? a_match : p_match);
   wire [15:0] cnt_inc = count + 16'h0001;

   always @(posedge aclk) begin
      if (!aresetn) begin
         count   <= `STMR_RST_CNT;
         on_prev <= 1'b0;
      end else begin
         on_prev <= counter_on;
         if (on_rise)
            count <= `STMR_RST_CNT;
         else if (cnt_clr)
            count <= `STMR_RST_CNT;
         else if (step)
            count <= cnt_inc;
      end
   end

   // ==========================================================
   // pwm compare: duty versus count in the period
   wire [16:0] p_span  = p_zero ? 17'h10000 : {1'b0, compare_p_value, 8'h00};
   wire [16:0] period  = period_duty_swap ? {1'b0, compare_a_value} : p_span;
   wire [16:0] duty    = period_duty_swap ? p_span : {1'b0, compare_a_value};
   wire        pwm_act = (duty >= period) | ({1'b0, count} < duty);

   // ==========================================================
   // output pin state
   reg  next_level;
   always @* begin
      next_level = out_level;
      if (on_rise && op_mode != `STMR_MODE_CAP)
         next_level = output_level_ctl;
      else if (op_mode == `STMR_MODE_CMP && a_match) begin
         case (pin_function)
            2'h0:    next_level = out_level;
            2'h1:    next_level = 1'b0;
            2'h2:    next_level = 1'b1;
            2'h3:    next_level = ~out_level;
            default: next_level = out_level;
         endcase
      end
   end

   reg  pin_raw;
   always @* begin
      case (op_mode)
         `STMR_MODE_CMP: pin_raw = out_level;
         `STMR_MODE_PWM: begin
            case (pin_function)
               2'h0:    pin_raw = ~output_level_ctl;
               2'h1:    pin_raw = output_level_ctl;
               2'h2:    pin_raw = pwm_act ? output_level_ctl : ~output_level_ctl;
               2'h3:    pin_raw = (counter_on & on_prev) ? output_level_ctl : ~output_level_ctl;
               default: pin_raw = ~output_level_ctl;
            endcase
         end
         default:        pin_raw = 1'b0;
      endcase
   end

   wire pin_drive = (op_mode == `STMR_MODE_CMP) | is_pwm;
   wire pin_value = pin_raw ^ output_invert;

   always @(posedge aclk) begin
      if (!aresetn) begin
         out_level      <= 1'b0;
         timer_out_pin0 <= 1'b0;
         timer_out_pin1 <= 1'b0;
         timer_out_en   <= 1'b0;
      end else begin
         out_level      <= next_level;
         timer_out_pin0 <= pin_drive ? pin_value : 1'b0;
         timer_out_pin1 <= pin_drive ? pin_value : 1'b0;
         timer_out_en   <= pin_drive;
      end
   end

   // ==========================================================
   // capture, flags, single pulse
   reg  cap_hit;
   always @* begin
      case (pin_function)
         2'h0:    cap_hit = cap_rise;
         2'h1:    cap_hit = cap_fall;
         2'h2:    cap_hit = cap_rise | cap_fall;
         default: cap_hit = 1'b0;
      endcase
   end
   wire cap_take = is_cap & counter_on & cap_hit;

   wire set_a  = cap_take | a_match;
   wire set_p  = p_match & ~(~is_pwm & ~is_cap & clear_source_sel) & ~single;
   wire ext_go = single & ~counter_on & (ext_rise | ext_fall);

   // ==========================================================
   // axi4-lite slave
   reg         aw_held;
   reg         w_held;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire        do_wr  = aw_held & w_held & ~s_axi_bvalid;
   wire        wr_lo  = do_wr & w_strb[0];
   wire        clr_fl = wr_lo & (aw_addr == `STMR_OFS_FLAGS);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held         <= 1'b0;
         w_held          <= 1'b0;
         aw_addr         <= 8'h00;
         w_data          <= 32'h00000000;
         w_strb          <= 4'h0;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= 2'h0;
         timer_control_a <= `STMR_RST_BYTE;
         timer_control_b <= `STMR_RST_BYTE;
         compare_a_value <= {`STMR_RST_BYTE, `STMR_RST_BYTE};
         compare_p_value <= `STMR_RST_BYTE;
         compare_a_flag  <= 1'b0;
         compare_p_flag  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
               `STMR_OFS_CTRL_A, `STMR_OFS_CTRL_B, `STMR_OFS_CMPA_LO,
               `STMR_OFS_CMPA_HI, `STMR_OFS_CMPP, `STMR_OFS_FLAGS,
               `STMR_OFS_CNT_LO, `STMR_OFS_CNT_HI: s_axi_bresp <= 2'h0;
               default:                            s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // register writes; a control a write wins over hardware events, a capture wins over compare a writes
         if (wr_lo && aw_addr == `STMR_OFS_CTRL_A)
            timer_control_a <= w_data[7:0] & `STMR_CTRL_A_MASK;
         else if (single && a_match)
            timer_control_a[`STMR_ON_BIT] <= 1'b0;
         else if (ext_go)
            timer_control_a[`STMR_ON_BIT] <= 1'b1;
         if (wr_lo && aw_addr == `STMR_OFS_CTRL_B)
            timer_control_b <= w_data[7:0];
         if (cap_take)
            compare_a_value <= count;
         else begin
            if (wr_lo && aw_addr == `STMR_OFS_CMPA_LO)
               compare_a_value[7:0] <= w_data[7:0];
            if (wr_lo && aw_addr == `STMR_OFS_CMPA_HI)
               compare_a_value[15:8] <= w_data[7:0];
         end
         if (wr_lo && aw_addr == `STMR_OFS_CMPP)
            compare_p_value <= w_data[7:0];
         // write one to clear; set wins
         if (set_a)
            compare_a_flag <= 1'b1;
         else if (clr_fl && w_data[`STMR_FLAG_A_BIT])
            compare_a_flag <= 1'b0;
         if (set_p)
            compare_p_flag <= 1'b1;
         else if (clr_fl && w_data[`STMR_FLAG_P_BIT])
            compare_p_flag <= 1'b0;
      end
   end

   reg [7:0] rd_byte;
   reg       rd_ok;
   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `STMR_OFS_CTRL_A:  rd_byte = timer_control_a & `STMR_CTRL_A_MASK;
         `STMR_OFS_CTRL_B:  rd_byte = timer_control_b;
         `STMR_OFS_CNT_LO:  rd_byte = count[7:0];
         `STMR_OFS_CNT_HI:  rd_byte = count[15:8];
         `STMR_OFS_CMPA_LO: rd_byte = compare_a_value[7:0];
         `STMR_OFS_CMPA_HI: rd_byte = compare_a_value[15:8];
         `STMR_OFS_CMPP:    rd_byte = compare_p_value;
         `STMR_OFS_FLAGS:   rd_byte = {6'h00, compare_p_flag, compare_a_flag};
         default: begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_byte};
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// >>> test/stmr_top_props.sv
// checker for stmr_top: bus answers and output pin relations
// assumes a bind to stmr_top, one write and one read at a time
module stmr_chk (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // register bus
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   // pins
   input wire        timer_out_pin0,
   input wire        timer_out_pin1,
   input wire        timer_out_en
);
   reg  [7:0] aw_q, wd_q, ar_q, cta, ctb;
   reg  [2:0] quiet;
   wire       wr_end = s_axi_bvalid & s_axi_bready;
   wire       rd_bad = (ar_q > 8'h1c) | (ar_q[1:0] != 2'h0);
   wire       fix_lvl = ~(ctb[4] ^ ctb[3]) ^ ctb[2];
   // ==========================================================
   // control shadows, quiet counts cycles since the last write
   always @(posedge aclk) begin
      if (s_axi_awvalid & s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_arvalid & s_axi_arready) ar_q <= s_axi_araddr;
      if (!aresetn) begin
         cta <= 8'h00;
         ctb <= 8'h00;
         quiet <= 3'h0;
      end else begin
         if (wr_end & (aw_q == 8'h00)) cta <= wd_q;
         if (wr_end & (aw_q == 8'h04)) ctb <= wd_q;
         quiet <= wr_end ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_unimpl;
      s_axi_rvalid && ar_q == 8'h00 |-> s_axi_rdata[2:0] == 3'h0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("control a low bits not zero");
   property p_rd_err;
      s_axi_rvalid && rd_bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read answered wrongly");
   property p_ar_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_pair;
      timer_out_pin0 == timer_out_pin1;
   endproperty
   a_pair: assert property (p_pair) else $error("output pins differ");
   property p_en_mode;
      quiet == 3'h7 |-> timer_out_en == (ctb[7:6] == 2'h0 || ctb[7:6] == 2'h2);
   endproperty
   a_en_mode: assert property (p_en_mode) else $error("pin enable wrong for mode");
   property p_on_init;
      $rose(cta[3]) && ctb[7:6] == 2'h0 |-> ##[0:3] timer_out_pin0 == (ctb[3] ^ ctb[2]);
   endproperty
   a_on_init: assert property (p_on_init) else $error("no initial level on start");
   property p_force;
      quiet == 3'h7 && cta[3] && ctb[7:6] == 2'h2 && !ctb[5] |-> timer_out_pin0 == fix_lvl;
   endproperty
   a_force: assert property (p_force) else $error("forced pwm level wrong");
endmodule

// >>> test/stmr_pin_model.sv
// pin side partner: bursts on the external clock pin, capture level
// assumes go inputs driven by the bench just after aclk edges
module stmr_pin_model (
   // clock
   input  wire  aclk,
   // requests
   input  wire  ext_go,
   input  wire  cap_go,
   // pins
   output logic ext_clock_pin,
   output logic capture_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] cnt;
   // one pulse per 8 cycles, pin idles low between bursts
   always @(posedge aclk) begin
      cnt <= ext_go ? cnt + 7'h01 : 7'h00;
      ext_clock_pin <= ext_go & cnt[2];
      capture_pin <= cap_go;
   end
endmodule

// >>> test/tb_standard_timer_register_control.sv
// bench for stmr_top: registers, clock sources, compare, pwm, capture
// assumes the pin model on the external pins and the checker bound below
module tb_standard_timer_register_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, high_clock, sub_clock, ext_go, cap_go;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, ext_clock_pin, capture_pin;
   logic        timer_out_pin0, timer_out_pin1, timer_out_en;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] v, w;
   int          bad_count, samples_checked;

   stmr_top dut_u (.*);
   stmr_pin_model pin_u (.*);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // tick strobes every second cycle
   always @(posedge aclk) begin
      high_clock <= aresetn ? ~high_clock : 1'b0;
      sub_clock <= aresetn ? ~sub_clock : 1'b0;
   end
   // ==========================================================
   // bus and compare tasks
   task automatic chk(input string s, input int lo, input int hi, input logic [15:0] g);
      samples_checked++;
      if ($isunknown(g) || $signed({1'b0, g}) < lo || $signed({1'b0, g}) > hi) begin
         bad_count++;
         $display("CHECK FAILED %s exp %0d..%0d got %h", s, lo, hi, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int er = 0);
      logic ha, hw, hb;
      logic [15:0] br;
      hb = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 40 && !hb; n++) begin
         @(negedge aclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid;
         br = hb ? {14'h0, s_axi_bresp} : 16'hxxxx;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", er, er, br);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] r);
      logic ha, hb;
      hb = 1'b0;
      r = 16'hxxxx;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 40 && !hb; n++) begin
         @(negedge aclk);
         ha = s_axi_arvalid & s_axi_arready;
         hb = s_axi_rvalid;
         if (hb) r = {6'h0, s_axi_rresp, s_axi_rdata[7:0]};
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic start(input logic [7:0] cb, input logic [7:0] ca);
      wr(8'h00, 8'h00);
      wr(8'h04, cb);
      wr(8'h00, ca);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4), v);
         chk("reset value", 0, 0, v);
      end
      rd(8'h20, v);
      chk("unmapped read", 16'h0200, 16'h0200, v);
      wr(8'h20, 8'h5a, 2);
      wr(8'h00, 8'hff);
      rd(8'h00, v);
      chk("control a", 16'h00f8, 16'h00f8, v);
      wr(8'h08, 8'h55);
      rd(8'h08, v);
      chk("counter low", 0, 0, v);
      for (int i = 0; i < 3; i++) begin
         wr(8'(16 + i * 4), 8'(52 + 77 * i));
         rd(8'(16 + i * 4), v);
         chk("compare value", (52 + 77 * i) % 256, (52 + 77 * i) % 256, v);
      end
   endtask
   task automatic t_pause;
      start(8'hc0, 8'h18);
      cyc(100);
      wr(8'h00, 8'h98);
      rd(8'h08, v);
      cyc(50);
      rd(8'h08, w);
      chk("paused count", v, v, w);
      wr(8'h00, 8'h18);
      cyc(50);
      wr(8'h00, 8'h10);
      rd(8'h08, w);
      chk("resumed count", v + 50, v + 70, w);
      cyc(30);
      rd(8'h08, v);
      chk("stopped count", w, w, v);
      wr(8'h00, 8'h18);
      rd(8'h08, v);
      chk("restart count", 0, 12, v);
   endtask
   task automatic t_src;
      int dv [8] = '{4, 1, 32, 128, 2, 2, 1, 1};
      int e;
      int t;
      for (int s = 0; s < 8; s++) begin
         start(8'hc0, 8'(s * 16 + 8));
         ext_go <= (s > 5);
         cyc(s > 5 ? 80 : 1024);
         ext_go <= 1'b0;
         cyc(10);
         wr(8'h00, 8'(s * 16));
         rd(8'h08, v);
         rd(8'h0c, w);
         e = s > 5 ? 10 : 1030 / dv[s];
         t = s > 5 ? 0 : 8;
         chk("source count", e - t, e + t, {w[7:0], v[7:0]});
      end
   endtask
   task automatic t_cmp;
      logic e;
      wr(8'h10, 8'h10);
      wr(8'h14, 8'h00);
      wr(8'h18, 8'h00);
      for (int i = 0; i < 16; i++) begin
         start({2'h0, i[1:0], i[2], i[3], 2'h0}, 8'h18);
         cyc(3);
         @(negedge aclk);
         chk("initial level", i[2] ^ i[3], i[2] ^ i[3], {15'h0, timer_out_pin0});
         chk("pin enable", 1, 1, {15'h0, timer_out_en});
         cyc(40);
         @(negedge aclk);
         e = i[1] ? (i[0] ? ~i[2] : 1'b1) : (i[0] ? 1'b0 : i[2]);
         chk("match level", e ^ i[3], e ^ i[3], {15'h0, timer_out_pin0});
      end
      rd(8'h1c, v);
      chk("match flags", 1, 1, v);
   endtask
   task automatic t_pwm;
      logic [7:0] cb [5] = '{8'ha9, 8'hac, 8'haa, 8'h98, 8'h88};
      logic [7:0] av [5] = '{8'h40, 8'h40, 8'hc8, 8'h40, 8'h40};
      int ex [5] = '{64, 192, 256, 256, 0};
      int k;
      wr(8'h18, 8'h01);
      for (int i = 0; i < 5; i++) begin
         wr(8'h10, av[i]);
         start(cb[i], 8'h18);
         cyc(300);
         k = 0;
         repeat (256) begin
            @(negedge aclk);
            k += timer_out_pin0;
         end
         chk("active cycles", ex[i] - 4, ex[i] + 4, 16'(k));
      end
   endtask
   task automatic t_one;
      int k;
      wr(8'h10, 8'h40);
      start(8'hb8, 8'h18);
      k = 0;
      repeat (100) begin
         @(negedge aclk);
         k += timer_out_pin0;
      end
      chk("pulse width", 60, 70, 16'(k));
      rd(8'h00, v);
      chk("pulse end", 16'h0010, 16'h0010, v);
      rd(8'h1c, v);
      chk("both flags", 3, 3, v);
      wr(8'h1c, 8'h03);
      rd(8'h1c, v);
      chk("flags cleared", 0, 0, v);
   endtask
   task automatic t_cap;
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, 8'h00);
         start(8'(64 + i * 16), 8'h18);
         cyc(20);
         cap_go <= 1'b1;
         cyc(20);
         cap_go <= 1'b0;
         cyc(20);
         rd(8'h10, v);
         chk("captured count", i == 3 ? 0 : i == 0 ? 20 : 40, i == 3 ? 0 : i == 0 ? 34 : 54, v);
      end
   endtask
   // ==========================================================
   // run and verdict
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      {aresetn, ext_go, cap_go} = 3'h0;
      bad_count = 0;
      samples_checked = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_pause;
      t_src;
      t_cmp;
      t_pwm;
      t_one;
      t_cap;
      give_verdict;
   end
   initial begin
      #3000000;
      bad_count++;
      give_verdict;
   end
endmodule

bind stmr_top stmr_chk chk_u (.*);
